// File: ddrpc_consts.svh
// Purpose: Shared constants of the double-rate pin cell.
// Assumes: Included by its bare name from each file that uses its constants.
// Notes:   Definitions only; no logic lives here.
`ifndef DDRPC_CONSTS_SVH
`define DDRPC_CONSTS_SVH

// Bit positions inside the four-bit input inversion mask.
`define DDRPC_INV_DATA 0
`define DDRPC_INV_CLOCK 1
`define DDRPC_INV_CE 2
`define DDRPC_INV_CLR 3
`define DDRPC_INV_W 4

// Clock rates and the highest memory link rate the cell is built for.
`define DDRPC_CLK_MHZ 25
`define DDRPC_MEM_CLK_MAX_MHZ 200
`define DDRPC_PIN_RATE_MBPS 400
`define DDRPC_BITS_PER_PERIOD (`DDRPC_PIN_RATE_MBPS / `DDRPC_MEM_CLK_MAX_MHZ)

// Reference clock cycles the strobe phase reference needs to settle.
`define DDRPC_SETTLE_CYCLES 256

// Default byte-lane width of one strobe group.
`define DDRPC_GROUP_W 8

// Reset values of the cell registers.
`define DDRPC_RST_BIT 1'b0
`define DDRPC_OE_OFF 1'b0

`endif

// File: ddrpc_pkg.sv
// Purpose: Types shared by the double-rate pin cell modules.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes:   Constants live in ddrpc_consts.svh; only types live here.
package ddrpc_pkg;

    // Operating mode of the pin cell.
    typedef enum logic [1:0] {mode_in, mode_out, mode_bidir} ddrpc_mode_t;

    // States of the strobe phase reference.
    typedef enum logic [1:0] {ref_idle, ref_count, ref_locked} ddrpc_ref_state_t;

endpackage

// File: ddrpc_ref_if.sv
// Purpose: Carries start, reference ticks and lock between cell and phase reference.
// Assumes: All three signals live in the clk domain.
// Notes:   The cell drives start and ref_tick; the reference drives locked.
interface ddrpc_ref_if;
    logic start;     // Level: run the reference while high.
    logic ref_tick;  // Pulse: one reference clock edge was seen.
    logic locked;    // Level: the delay setting has settled.

    modport cell_side (output start, output ref_tick, input locked);
    modport ref_side (input start, input ref_tick, output locked);
endinterface

// File: ddrpc_sync.sv
// Purpose: Two-flop synchroniser for levels entering from outside clk.
// Assumes: Each bit is an independent level; no bus coherence is promised.
// Notes:   Only the second flop is visible to the rest of the design.
module ddrpc_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q; // First stage; read by the second stage alone.

    // The two stages shift together; reset clears both.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule

// File: ddrpc_phase_ref.sv
// Purpose: Strobe phase reference model that settles after a fixed tick count.
// Assumes: ref_tick marks one rising edge of the reference clock.
// Notes:   Dropping start returns the reference to idle and clears the lock.
`include "ddrpc_consts.svh"
module ddrpc_phase_ref import ddrpc_pkg::*; #(
    parameter int SETTLE = `DDRPC_SETTLE_CYCLES
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Link to the pin cell.
    ddrpc_ref_if.ref_side ref_if
);

    localparam int CW = $clog2(SETTLE);
    localparam logic [CW-1:0] LAST = CW'(SETTLE - 1);

    ddrpc_ref_state_t state_q, state_d; // Reference state.
    logic [CW-1:0] cnt_q, cnt_d; // Reference ticks seen since start.
    logic locked_q; // Registered lock flag.

    assign ref_if.locked = locked_q;

    // Count reference ticks; lock on the last one of the settling window.
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ref_idle: begin
                cnt_d = '0;
                if (ref_if.start) begin
                    state_d = ref_count;
                end
            end
            ref_count: begin
                if (!ref_if.start) begin
                    state_d = ref_idle;
                end else if (ref_if.ref_tick) begin
                    if (cnt_q == LAST) begin
                        state_d = ref_locked;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
            end
            default: begin
                if (!ref_if.start) begin
                    state_d = ref_idle;
                end
            end
        endcase
    end

    // State, count and lock flag registers.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ref_idle;
            cnt_q <= '0;
            locked_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            locked_q <= (state_d == ref_locked);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_lock_on_last: assert property (
        state_q == ref_count && ref_if.start && ref_if.ref_tick && cnt_q == LAST |=> locked_q)
        else $error("reference did not lock on its last settling tick");
    a_no_early_lock: assert property (
        $rose(locked_q) |-> $past(cnt_q) == LAST && $past(state_q) == ref_count)
        else $error("reference locked before the settling window ended");
    c_ref_locks: cover property ($rose(locked_q));

endmodule

// File: ddrpc_pin_cell.sv
// Purpose: Double-rate pin cell lane: input capture, output mux, output enable.
// Assumes: clk is far faster than the link clock, each link half period
//          spans at least two clk cycles, and pins meet the sync flops.
// Notes:   The link clock and strobe are sampled, not used as clocks.
//
// Notes on behaviour
// - Two input registers capture on opposite edges.
// - Latch aligns both input bits to rising edge.
// - Two output registers load on rising edge.
// - Clock level selects output register, double rate.
// - First bit high phase, second bit low.
// - Bidirectional mode shares one tri-state driver.
// - Falling-edge enable register for memory bus.
// - Enable active high, option for active low.
// - Data, clocks, clock enables, clear have inversion options.
// - Output clock enable defaults asserted, loads.
// - Deasserted output enable holds output registers.
// - Six registers plus one input latch.
// - Strobe capture only on data pins.
// - Strobe bus output only on strobe pins.
// - Groups of 8, 16 or 32 data pins.
// - Side banks ignore strobe, use link clock.
// - 200 MHz link gives two bits per period.
// - Enable and output registers share clock, enable.
// - Reference settles in 256 cycles before valid data.
`include "ddrpc_consts.svh"
module ddrpc_pin_cell import ddrpc_pkg::*; #(
    parameter int W = `DDRPC_GROUP_W,
    parameter bit IS_DQ_PIN = 1'b1,
    parameter bit IS_DQS_PIN = 1'b0,
    parameter bit HAS_PHASE_SHIFT = 1'b1,
    parameter bit HAS_OUT_CE = 1'b0,
    parameter int SETTLE = `DDRPC_SETTLE_CYCLES
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Configuration levels.
    input wire ddrpc_mode_t cfg_mode,
    input wire logic [`DDRPC_INV_W-1:0] cfg_invert,
    input wire logic cfg_oe_active_low,
    input wire logic cfg_neg_oe,
    input wire logic cfg_use_strobe,
    input wire logic cfg_side_bank,
    // Fabric side controls and data.
    input wire logic [W-1:0] dout_a,
    input wire logic [W-1:0] dout_b,
    input wire logic oe_req,
    input wire logic ce_in,
    input wire logic ce_out,
    input wire logic sclr,
    input wire logic ref_start,
    // Fabric side results.
    output logic [W-1:0] din_hi,
    output logic [W-1:0] din_lo,
    output logic din_valid,
    output logic ref_locked,
    // Link side pins.
    input wire logic mem_clk,
    input wire logic dqs_in,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out,
    output logic pin_oe,
    output logic strobe_bus
);

    // ************************************************************
    // Pin synchronisation and input conditioning
    // ************************************************************

    localparam int BITS = `DDRPC_BITS_PER_PERIOD; // Bits per pin per link period.
    localparam bit GROUP_OK = (W == 8) || (W == 16) || (W == 32);

    logic [W+1:0] pins_s; // Strobe, link clock and data after two flops.
    logic [W-1:0] pin_d; // Conditioned pin data.
    logic clk_lvl; // Conditioned link clock level.
    logic dqs_lvl; // Conditioned strobe level.
    logic strobe_ok; // Strobe may clock the input registers.
    logic cap_lvl; // Level of whichever clock captures input data.
    logic cap_prev_q; // Capture clock level one cycle ago.
    logic lk_prev_q; // Link clock level one cycle ago.
    logic cap_rise, cap_fall, lk_rise, lk_fall; // Detected edges.
    logic ce_i, ce_o, clr; // Conditioned enables and clear.
    logic in_act, out_act; // Mode decodes.
    logic data_ok; // Captured data may be trusted.
    logic [W-1:0] dout_a_d, dout_b_d; // Conditioned fabric words.
    logic oe_eff; // Enable request at the cell's internal polarity.

    // Data, clock and strobe are synchronised together so their relative
    // timing survives; the design relies on that skew being one clk cycle.
    ddrpc_sync #(.W(W + 2)) u_sync (
        .clk(clk),
        .rstn(rstn),
        .d({dqs_in, mem_clk, pin_in}),
        .q(pins_s)
    );

    // Data, clocks, clock enable and clear pass their inversion options; oe_req and ref_start do not.
    assign pin_d = pins_s[W-1:0] ^ {W{cfg_invert[`DDRPC_INV_DATA]}};
    assign clk_lvl = pins_s[W] ^ cfg_invert[`DDRPC_INV_CLOCK];
    assign dqs_lvl = pins_s[W+1] ^ cfg_invert[`DDRPC_INV_CLOCK];
    assign dout_a_d = dout_a ^ {W{cfg_invert[`DDRPC_INV_DATA]}};
    assign dout_b_d = dout_b ^ {W{cfg_invert[`DDRPC_INV_DATA]}};
    assign ce_i = ce_in ^ cfg_invert[`DDRPC_INV_CE];
    assign clr = sclr ^ cfg_invert[`DDRPC_INV_CLR];

    // Without the optional output enable the output registers load on every link rise outside input mode.
    assign ce_o = HAS_OUT_CE ? (ce_out ^ cfg_invert[`DDRPC_INV_CE]) : 1'b1;

    // The strobe clocks capture only on data pins of a bank with phase
    // shift; a side bank drops the strobe and uses the link clock.
    assign strobe_ok = cfg_use_strobe && IS_DQ_PIN && HAS_PHASE_SHIFT && !cfg_side_bank;
    assign cap_lvl = strobe_ok ? dqs_lvl : clk_lvl;

    // Edge detection compares the settled level with its last value.
    assign cap_rise = cap_lvl && !cap_prev_q;
    assign cap_fall = !cap_lvl && cap_prev_q;
    assign lk_rise = clk_lvl && !lk_prev_q;
    assign lk_fall = !clk_lvl && lk_prev_q;

    assign in_act = (cfg_mode != mode_out);
    assign out_act = (cfg_mode != mode_in);
    assign oe_eff = oe_req ^ cfg_oe_active_low;

    // Data captured through the strobe is only good once the reference
    // has settled; the link clock path needs no settling.
    assign data_ok = !strobe_ok || ref_locked;

    // Previous levels for edge detection.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cap_prev_q <= `DDRPC_RST_BIT;
            lk_prev_q <= `DDRPC_RST_BIT;
        end else begin
            cap_prev_q <= cap_lvl;
            lk_prev_q <= clk_lvl;
        end
    end

    // ************************************************************
    // Strobe phase reference
    // ************************************************************

    ddrpc_ref_if ref_bus ();

    assign ref_bus.start = ref_start;
    assign ref_bus.ref_tick = lk_rise;

    ddrpc_phase_ref #(.SETTLE(SETTLE)) u_ref (
        .clk(clk),
        .rstn(rstn),
        .ref_if(ref_bus)
    );

    // ************************************************************
    // Double-rate input path
    // ************************************************************

    logic [W-1:0] in_pos_q; // Input register on the rising edge.
    logic [W-1:0] in_neg_q; // Input register on the falling edge.
    logic [W-1:0] latch_q; // Latch, open while the capture clock is high.
    logic cap_en; // Input registers may load.

    assign cap_en = in_act && ce_i && !clr;

    // Successive bits fall into alternate registers on opposite edges.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            in_pos_q <= '0;
            in_neg_q <= '0;
        end else if (clr) begin
            in_pos_q <= '0;
            in_neg_q <= '0;
        end else if (cap_en && cap_rise) begin
            in_pos_q <= pin_d;
        end else if (cap_en && cap_fall) begin
            in_neg_q <= pin_d;
        end
    end

    // The latch follows the rising-edge register through the high phase
    // and holds through the low phase, so the first bit is still there
    // when the next rising edge also picks up the second bit.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            latch_q <= '0;
        end else if (clr) begin
            latch_q <= '0;
        end else if (cap_lvl && !cap_rise) begin
            latch_q <= in_pos_q;
        end
    end

    // Both bits of one period leave together on the next rising edge;
    // BITS words per period reach the fabric in parallel.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            din_hi <= '0;
            din_lo <= '0;
            din_valid <= 1'b0;
        end else begin
            din_valid <= cap_en && cap_rise && data_ok && (BITS == 2);
            if (clr) begin
                din_hi <= '0;
                din_lo <= '0;
            end else if (cap_en && cap_rise) begin
                din_hi <= latch_q;
                din_lo <= in_neg_q;
            end
        end
    end

    // ************************************************************
    // Double-rate output path and output enable
    // ************************************************************

    logic [W-1:0] out_a_q, out_b_q; // Output registers, first and second bit.
    logic [W-1:0] out_a_n, out_b_n; // Their values after this cycle.
    logic oe_pos_q; // Output enable register on the rising edge.
    logic oe_neg_q; // Output enable register on the falling edge.
    logic oe_sel; // Enable register chosen by configuration.
    logic out_load; // Output registers load this cycle.

    // Both output registers load on the link's rising edge while enabled.
    assign out_load = lk_rise && ce_o && out_act;
    assign out_a_n = clr ? '0 : (out_load ? dout_a_d : out_a_q);
    assign out_b_n = clr ? '0 : (out_load ? dout_b_d : out_b_q);
    assign oe_sel = cfg_neg_oe ? oe_neg_q : oe_pos_q;

    // The two output registers: first bit and second bit.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_a_q <= '0;
            out_b_q <= '0;
        end else begin
            out_a_q <= out_a_n;
            out_b_q <= out_b_n;
        end
    end

    // The rising-edge enable register runs from the same clock edge as the output
    // registers, and both share their clock enable. The falling-edge copy keeps
    // the driver off until the falling edge after the request.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            oe_pos_q <= `DDRPC_OE_OFF;
            oe_neg_q <= `DDRPC_OE_OFF;
        end else if (clr) begin
            oe_pos_q <= `DDRPC_OE_OFF;
            oe_neg_q <= `DDRPC_OE_OFF;
        end else if (lk_rise && ce_o) begin
            oe_pos_q <= oe_eff;
        end else if (lk_fall && ce_o) begin
            oe_neg_q <= oe_eff;
        end
    end

    // The link clock level picks the register: first bit while high,
    // second while low, so the pin toggles at twice the word rate. The
    // pin lags the link clock by the sync and this flop, a known skew.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_out <= '0;
            pin_oe <= `DDRPC_OE_OFF;
            strobe_bus <= 1'b0;
            ref_locked <= 1'b0;
        end else begin
            pin_out <= clk_lvl ? out_a_n : out_b_n;
            pin_oe <= out_act && oe_sel;
            strobe_bus <= IS_DQS_PIN && dqs_lvl;
            ref_locked <= ref_bus.locked;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_group_width: assert property (GROUP_OK)
        else $error("group width is not 8, 16 or 32");
    a_rise_capture: assert property (
        cap_en && cap_rise |=> in_pos_q == $past(pin_d) && $stable(in_neg_q))
        else $error("rising-edge input register missed its bit");
    a_fall_capture: assert property (
        cap_en && cap_fall |=> in_neg_q == $past(pin_d) && $stable(in_pos_q))
        else $error("falling-edge input register missed its bit");
    a_pair_aligned: assert property (
        cap_en && cap_rise |=> din_hi == $past(latch_q) && din_lo == $past(in_neg_q))
        else $error("input pair not aligned to the rising edge");
    a_out_load: assert property (
        out_load && !clr |=> out_a_q == $past(dout_a_d) && out_b_q == $past(dout_b_d))
        else $error("output registers did not load on the rising edge");
    a_out_hold: assert property (
        !ce_o && !clr |=> $stable(out_a_q) && $stable(out_b_q))
        else $error("output registers changed while disabled");
    a_high_first: assert property (
        clk_lvl && !clr |=> pin_out == out_a_q)
        else $error("first bit not on the pin in the high phase");
    a_low_second: assert property (
        !clk_lvl && !clr |=> pin_out == out_b_q)
        else $error("second bit not on the pin in the low phase");
    a_neg_oe_wait: assert property (
        !lk_fall && !clr |=> $stable(oe_neg_q))
        else $error("falling-edge enable moved off a falling edge");
    a_oe_polarity: assert property (
        lk_rise && ce_o && !clr |=> oe_pos_q == ($past(oe_req) ^ $past(cfg_oe_active_low)))
        else $error("enable register ignored the polarity option");
    a_side_bank: assert property (
        cfg_side_bank |-> cap_lvl == clk_lvl)
        else $error("side bank captured with the strobe");
    a_strobe_pin: assert property (
        !IS_DQS_PIN |-> !strobe_bus)
        else $error("strobe bus driven from a non-strobe pin");
    a_valid_lock: assert property (
        din_valid && $past(strobe_ok) |-> $past(ref_locked))
        else $error("strobe data marked valid before the reference settled");

    // The latch must track the rising register for the whole high phase,
    // or the first bit of a pair would come from the period before.
    a_latch_high: assert property (
        cap_lvl && !cap_rise && !clr |=> latch_q == $past(in_pos_q))
        else $error("input latch did not follow the rising register");
    // A refused capture must never produce a pair for the fabric.
    a_in_refused: assert property (
        !cap_en |=> !din_valid)
        else $error("pair marked valid while capture was refused");
    // Clear empties the output registers and the pair in one cycle.
    a_clear_empties: assert property (
        clr |=> out_a_q == '0 && out_b_q == '0 && din_hi == '0 && din_lo == '0)
        else $error("clear left a cell register loaded");
    // The enable registers share the output clock enable.
    a_oe_shared_ce: assert property (
        !ce_o && !clr |=> $stable(oe_pos_q) && $stable(oe_neg_q))
        else $error("enable registers moved while the output enable was low");
    // An input-only lane never turns its driver on.
    a_input_no_drive: assert property (
        cfg_mode == mode_in |=> !pin_oe)
        else $error("driver enabled in input-only mode");

    c_in_pair: cover property (din_valid ##[1:16] din_valid);
    c_bidir_drive: cover property (cfg_mode == mode_bidir && $rose(pin_oe));
    c_out_held: cover property (!ce_o [*3] ##1 out_load);

endmodule

// File: ddrpc_mem_model.sv
// Purpose: Behavioural memory on the far side of the pin cell lane.
// Assumes: Called by the bench; link clock period 320 ns, half periods of 160 ns.
// Notes:   Each read word is centred on its link clock edge; clock stands still between frames.
module ddrpc_mem_model #(
    parameter int W = 8
) (
    // Link clock and strobe toward the cell.
    output logic mem_clk,
    output logic dqs_in,
    // Read data toward the cell, write data and enable from it.
    output logic [W-1:0] pin_in,
    input wire logic [W-1:0] pin_out,
    input wire logic pin_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // Frame storage
    // ************************************************************
    logic [W-1:0] rd_a [8];  // First read word of each period.
    logic [W-1:0] rd_b [8];  // Second read word of each period.
    logic [W-1:0] wr_a [8];  // Pin word seen just before each fall.
    logic [W-1:0] wr_b [8];  // Pin word seen just before each rise.
    logic oe_fall [8];       // Driver enable seen just before each fall.
    logic strobe_on;         // Low keeps the strobe still, as on a side bank.
    // Idle state: clock low, data parked.
    initial begin
        mem_clk = 1'b0;
        dqs_in = 1'b0;
        pin_in = '0;
        strobe_on = 1'b1;
    end
    // One frame of n link periods; the 7 ns lead keeps edges off clk edges.
    task automatic frame(input int n);
        #7;
        for (int i = 0; i < n; i++) begin
            pin_in = rd_a[i];
            #80;
            wr_b[i] = pin_out;
            mem_clk = 1'b1;
            dqs_in = strobe_on;
            #80;
            pin_in = rd_b[i];
            #80;
            wr_a[i] = pin_out;
            oe_fall[i] = pin_oe;
            mem_clk = 1'b0;
            dqs_in = 1'b0;
            #80;
        end
        // Released lines show the inverse so a stale value never passes.
        pin_in = ~pin_in;
    endtask
endmodule

// File: ddrpc_pin_cell_tb_top.sv
// Purpose: Self-checking bench of the double-rate pin cell lane.
// Assumes: Reference settle count shortened to 4 link rises.
// Notes:   Pin values are judged at the link edges, where they are settled.
`include "ddrpc_consts.svh"
module ddrpc_pin_cell_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ddrpc_pkg::*;
    localparam int W = 8;
    localparam int SETTLE = 4;
    // ************************************************************
    // Signals
    // ************************************************************
    logic clk = 1'b0, rstn = 1'b0;
    ddrpc_mode_t cfg_mode = mode_in;
    logic [`DDRPC_INV_W-1:0] cfg_invert = '0;
    logic cfg_oe_active_low = 1'b0, cfg_neg_oe = 1'b1, cfg_use_strobe = 1'b0;
    logic cfg_side_bank = 1'b0, oe_req = 1'b0, ce_in = 1'b1, ce_out = 1'b1;
    logic sclr = 1'b0, ref_start = 1'b0;
    logic [W-1:0] dout_a = '0, dout_b = '0, din_hi, din_lo, pin_in, pin_out;
    logic din_valid, ref_locked, mem_clk, dqs_in, pin_oe, strobe_bus;
    logic [W-1:0] got_hi [$], got_lo [$];  // Pairs handed to the fabric.
    int bad_count = 0, total_checks = 0;
    ddrpc_pin_cell #(.W(W), .HAS_OUT_CE(1'b1), .SETTLE(SETTLE)) dut (.clk, .rstn,
        .cfg_mode, .cfg_invert, .cfg_oe_active_low, .cfg_neg_oe, .cfg_use_strobe,
        .cfg_side_bank, .dout_a, .dout_b, .oe_req, .ce_in, .ce_out, .sclr, .ref_start,
        .din_hi, .din_lo, .din_valid, .ref_locked, .mem_clk, .dqs_in, .pin_in,
        .pin_out, .pin_oe, .strobe_bus);
    ddrpc_mem_model #(.W(W)) mem (.mem_clk, .dqs_in, .pin_in, .pin_out, .pin_oe);
    // Clock at 25 MHz.
    always #20 clk = ~clk;
    // Collect every pair that the cell marks valid.
    always @(posedge clk) begin
        if (din_valid === 1'b1) begin
            got_hi.push_back(din_hi);
            got_lo.push_back(din_lo);
        end
    end
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(string what, logic [W-1:0] seen, logic [W-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // A frame, then time for the last fall to cross the synchronisers.
    task automatic run(int n);
        @(posedge clk);
        mem.frame(n);
        repeat (10) @(posedge clk);
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    // Output words on the pin, hold while ce_out is low, enable timing.
    task automatic t_output(logic [W-1:0] a, logic [W-1:0] b, logic ce, logic [W-1:0] ea,
                            logic [W-1:0] eb, logic low, logic req, logic eoe0, logic eoe);
        @(posedge clk);
        cfg_mode <= mode_out;
        dout_a <= a;
        dout_b <= b;
        ce_out <= ce;
        cfg_oe_active_low <= low;
        oe_req <= req;
        run(4);
        for (int i = 1; i < 4; i++) begin
            check("pin_out high phase", mem.wr_a[i], ea);
            check("pin_out low phase", mem.wr_b[i], eb);
        end
        check("pin_oe before first fall", mem.oe_fall[0], eoe0);
        check("pin_oe after frame", pin_oe, eoe);
    endtask
    // Seven read periods; exp_cnt pairs must reach the fabric.
    task automatic t_input(ddrpc_mode_t m, logic ce, logic inv, logic strb, logic side,
                           int exp_cnt);
        int k0;
        for (int i = 0; i < 7; i++) begin
            mem.rd_a[i] = 8'(8'h1D * (i + 1));
            mem.rd_b[i] = mem.rd_a[i] ^ 8'hB7;
        end
        mem.strobe_on = !side;
        @(posedge clk);
        cfg_mode <= m;
        ce_in <= ce;
        cfg_invert <= {3'h0, inv};
        cfg_use_strobe <= strb;
        cfg_side_bank <= side;
        ref_start <= strb & !side;
        got_hi.delete();
        got_lo.delete();
        run(7);
        check("pair count", 8'(got_hi.size()), 8'(exp_cnt));
        // The last pair holds period 5; a frame's first rise hands over a stale pair.
        k0 = 6 - got_hi.size();
        for (int k = 0; k < got_hi.size(); k++) begin
            if (k + k0 >= 0) begin
                check("din_hi", got_hi[k], mem.rd_a[k + k0] ^ {W{inv}});
                check("din_lo", got_lo[k], mem.rd_b[k + k0] ^ {W{inv}});
            end
        end
        check("ref_locked", ref_locked, strb & !side);
        check("strobe_bus", strobe_bus, 1'b0);
        if (m == mode_in) check("pin_oe input mode", pin_oe, 1'b0);
    endtask
    // Synchronous clear empties the pair and the pin word.
    task automatic t_clear();
        @(posedge clk);
        sclr <= 1'b1;
        @(posedge clk);
        sclr <= 1'b0;
        repeat (2) @(posedge clk);
        check("din_hi after clear", din_hi, '0);
        check("pin_out after clear", pin_out, '0);
    endtask
    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_output(8'hA5, 8'h3C, 1'b1, 8'hA5, 8'h3C, 1'b0, 1'b1, 1'b0, 1'b1);
        t_output(8'h5A, 8'hC3, 1'b0, 8'hA5, 8'h3C, 1'b0, 1'b0, 1'b1, 1'b1);
        t_output(8'h0F, 8'hF0, 1'b1, 8'h0F, 8'hF0, 1'b1, 1'b1, 1'b1, 1'b0);
        t_input(mode_in, 1'b1, 1'b0, 1'b0, 1'b0, 7);
        t_input(mode_bidir, 1'b1, 1'b0, 1'b0, 1'b0, 7);
        t_input(mode_in, 1'b1, 1'b1, 1'b0, 1'b0, 7);
        t_input(mode_out, 1'b1, 1'b0, 1'b0, 1'b0, 0);
        t_input(mode_in, 1'b0, 1'b0, 1'b0, 1'b0, 0);
        t_input(mode_in, 1'b1, 1'b0, 1'b1, 1'b0, 7 - SETTLE);
        t_input(mode_in, 1'b1, 1'b0, 1'b1, 1'b1, 7);
        t_clear();
        wrap_up();
    end
    // The scenarios take about 25 us; a hang is cut off well beyond that.
    initial begin
        #200000;
        bad_count++;
        wrap_up();
    end
endmodule
